// ==== design/monitor_channel.v ====
// One analog monitor channel: offset, scale, absolute value and clamp
`timescale 1ns/10ps
module monitor_channel
(
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Settings
   input wire [4:0] var_sel,
   input wire signed [31:0] offset,
   input wire [31:0] scale,
   input wire abs_mode,
   // Monitored variables, 25 of 32 bits each
   input wire [799:0] variables,
   // Result in millivolts
   output reg signed [15:0] mv_out
);
`include "output_map_regs.vh"
   reg signed [31:0] picked;
   reg signed [63:0] diff;
   reg signed [63:0] quot;
   reg signed [63:0] mag;
   always @*
   begin
      if (var_sel <= `MON_VAR_LAST)
         picked = variables[var_sel*32 +: 32];
      else
         picked = 32'sh00000000;
      diff = ($signed({{32{picked[31]}}, picked}) - $signed({{32{offset[31]}}, offset}))
         * 64'sd1000;
      // Zero scale treated as one
      if (scale == 32'h00000000)
         quot = diff;
      else
         quot = diff / $signed({32'h00000000, scale});
      if (abs_mode && quot < 0)
         mag = -quot;
      else
         mag = quot;
   end
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         mv_out <= 16'sh0000;
      else if (mag > $signed({32'h00000000, `MON_LIMIT_MV}))
         mv_out <= 16'sh0FA0;
      else if (mag < -$signed({32'h00000000, `MON_LIMIT_MV}))
         mv_out <= -16'sh0FA0;
      else
         mv_out <= mag[15:0];
   end
endmodule // monitor_channel

// ==== design/output_map.v ====
// Digital output function map and analog monitor register block on AHB-Lite
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Four output pins each have a setting register choosing one of eleven functions.
// - Setting bits 7..0 pick the function, bit 15 picks contact A or B, 14..8 reserved.
// - Codes 0x00 to 0x0B decode to none, brake, alarm, ready, and the other status flags.
// - Monitor output is clamped to the range minus four to plus four volts.
// - Monitor mode 1 outputs the absolute value of the result.
// - Each channel picks one internal variable with codes 0x00 to 0x18.
// - Channel one outputs its value minus its offset divided by its scale.
// - Channel two does the same with its own selection, offset and scale; both channels share the mode register.
// - Offsets are signed 32-bit and scales unsigned 32-bit, both writable.
// - A pin with no function and its force mask bit set follows the force value bit.
module output_map
#(
   parameter NUM_OUT = 4
)
(
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Status functions from the drive
   input wire brake_flag,
   input wire alarm_flag,
   input wire servo_ready_flag,
   input wire zero_speed_flag,
   input wire in_position_first,
   input wire torque_limit_flag,
   input wire speed_limit_flag,
   input wire speed_reached_flag,
   input wire warning_flag,
   input wire rotation_detected_flag,
   input wire in_position_second,
   // Monitored variables, 25 words of 32 bits
   input wire [799:0] monitor_vars,
   // Pins and monitor outputs
   output reg [NUM_OUT-1:0] out_pin,
   output reg signed [15:0] mon_ch1_mv,
   output reg signed [15:0] mon_ch2_mv
);
`include "output_map_regs.vh"
   reg [15:0] out_sel_reg [0:NUM_OUT-1];
   reg [15:0] mon_mode_reg;
   reg [15:0] mon_ch1_sel_reg;
   reg [15:0] mon_ch2_sel_reg;
   reg [31:0] mon_ch1_ofs_reg;
   reg [31:0] mon_ch2_ofs_reg;
   reg [31:0] mon_ch1_scl_reg;
   reg [31:0] mon_ch2_scl_reg;
   reg [31:0] force_val_reg;
   reg [31:0] force_mask_reg;
   reg wr_pend_reg;
   reg [17:0] wr_addr_reg;
   reg [31:0] rd_next;
   wire [15:0] func_vec;
   wire [NUM_OUT-1:0] pin_next;
   wire signed [15:0] ch1_mv;
   wire signed [15:0] ch2_mv;
   wire access;
   wire addr_hit_out;
   wire [1:0] out_idx;
   // Function code to flag, code 0 and reserved codes read as inactive
   assign func_vec = {4'h0, in_position_second, rotation_detected_flag, warning_flag,
      speed_reached_flag, speed_limit_flag, torque_limit_flag, in_position_first,
      zero_speed_flag, servo_ready_flag, alarm_flag, brake_flag, 1'b0};
   assign access = hsel & hready & htrans[1];
   assign addr_hit_out = (haddr[31:4] == {10'h000, `ADDR_OUT1_SEL} >> 4) &&
      (haddr[1:0] == 2'b00);
   assign out_idx = haddr[3:2];
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g = g + 1)
      begin : pin_gen
         wire [7:0] code;
         wire active;
         assign code = out_sel_reg[g][`SEL_FUNC_MSB:0];
         assign active = (code <= `FUNC_LAST) ? func_vec[code[3:0]] : 1'b0;
         assign pin_next[g] = (code == `FUNC_NONE && force_mask_reg[`FORCE_LSB + g]) ?
            force_val_reg[`FORCE_LSB + g] :
            (active ^ out_sel_reg[g][`SEL_POL_BIT]);
      end
   endgenerate
   // Read mux, unmapped addresses read zero
   always @*
   begin
      rd_next = 32'h00000000;
      if (addr_hit_out)
         rd_next = {16'h0000, out_sel_reg[out_idx]};
      else
         case (haddr[17:0])
            `ADDR_MON_MODE: rd_next = {16'h0000, mon_mode_reg};
            `ADDR_MON_CH1_SEL: rd_next = {16'h0000, mon_ch1_sel_reg};
            `ADDR_MON_CH2_SEL: rd_next = {16'h0000, mon_ch2_sel_reg};
            `ADDR_MON_CH1_OFS: rd_next = mon_ch1_ofs_reg;
            `ADDR_MON_CH2_OFS: rd_next = mon_ch2_ofs_reg;
            `ADDR_MON_CH1_SCL: rd_next = mon_ch1_scl_reg;
            `ADDR_MON_CH2_SCL: rd_next = mon_ch2_scl_reg;
            `ADDR_FORCE_VAL: rd_next = force_val_reg;
            `ADDR_FORCE_MASK: rd_next = force_mask_reg;
            `ADDR_OUT_STATUS: rd_next = {28'h0000000, out_pin};
            default: rd_next = 32'h00000000;
         endcase
      if (haddr[31:18] != 14'h0000)
         rd_next = 32'h00000000;
   end
   // Bus phases
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 18'h00000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= access & hwrite;
         if (access)
            wr_addr_reg <= haddr[17:0];
         if (access && !hwrite)
            hrdata <= rd_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   // Register writes in the data phase
   integer i;
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (i = 0; i < NUM_OUT; i = i + 1)
            out_sel_reg[i] <= `RST_SEL;
         mon_mode_reg <= 16'h0000;
         mon_ch1_sel_reg <= 16'h0000;
         mon_ch2_sel_reg <= 16'h0000;
         mon_ch1_ofs_reg <= 32'h00000000;
         mon_ch2_ofs_reg <= 32'h00000000;
         mon_ch1_scl_reg <= `RST_SCALE;
         mon_ch2_scl_reg <= `RST_SCALE;
         force_val_reg <= 32'h00000000;
         force_mask_reg <= 32'h00000000;
      end
      else if (wr_pend_reg)
      begin
         if (wr_addr_reg[17:4] == `ADDR_OUT1_SEL >> 4)
            out_sel_reg[wr_addr_reg[3:2]] <= hwdata[15:0] & `SEL_WRITE_MASK;
         case (wr_addr_reg)
            `ADDR_MON_MODE: mon_mode_reg <= hwdata[15:0] & `MON_MODE_ABS;
            `ADDR_MON_CH1_SEL: mon_ch1_sel_reg <= hwdata[15:0] & `MON_SEL_MASK;
            `ADDR_MON_CH2_SEL: mon_ch2_sel_reg <= hwdata[15:0] & `MON_SEL_MASK;
            `ADDR_MON_CH1_OFS: mon_ch1_ofs_reg <= hwdata;
            `ADDR_MON_CH2_OFS: mon_ch2_ofs_reg <= hwdata;
            `ADDR_MON_CH1_SCL: mon_ch1_scl_reg <= hwdata;
            `ADDR_MON_CH2_SCL: mon_ch2_scl_reg <= hwdata;
            `ADDR_FORCE_VAL: force_val_reg <= {12'h000, hwdata[19:16], 16'h0000};
            `ADDR_FORCE_MASK: force_mask_reg <= {12'h000, hwdata[19:16], 16'h0000};
            default: ;
         endcase
      end
   end
   // Monitor channels
   monitor_channel ch1_inst
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .var_sel(mon_ch1_sel_reg[4:0]),
      .offset(mon_ch1_ofs_reg),
      .scale(mon_ch1_scl_reg),
      .abs_mode(mon_mode_reg[0]),
      .variables(monitor_vars),
      .mv_out(ch1_mv)
   );
   monitor_channel ch2_inst
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .var_sel(mon_ch2_sel_reg[4:0]),
      .offset(mon_ch2_ofs_reg),
      .scale(mon_ch2_scl_reg),
      .abs_mode(mon_mode_reg[0]),
      .variables(monitor_vars),
      .mv_out(ch2_mv)
   );
   // Output flops
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_pin <= {NUM_OUT{1'b0}};
         mon_ch1_mv <= 16'sh0000;
         mon_ch2_mv <= 16'sh0000;
      end
      else
      begin
         out_pin <= pin_next;
         mon_ch1_mv <= ch1_mv;
         mon_ch2_mv <= ch2_mv;
      end
   end
endmodule // output_map

// ==== design/output_map_regs.vh ====
// Register map, field positions, reset values and limits of the output map
`ifndef OUTPUT_MAP_REGS_VH
`define OUTPUT_MAP_REGS_VH
// Register indices; byte address is four times the index
`define IDX_OUT1_SEL 16'h2210
`define IDX_OUT2_SEL 16'h2211
`define IDX_OUT3_SEL 16'h2212
`define IDX_OUT4_SEL 16'h2213
`define IDX_MON_MODE 16'h2220
`define IDX_MON_CH1_SEL 16'h2221
`define IDX_MON_CH2_SEL 16'h2222
`define IDX_MON_CH1_OFS 16'h2223
`define IDX_MON_CH2_OFS 16'h2224
`define IDX_MON_CH1_SCL 16'h2225
`define IDX_MON_CH2_SCL 16'h2226
`define IDX_FORCE_VAL 16'h2230
`define IDX_FORCE_MASK 16'h2231
`define IDX_OUT_STATUS 16'h2232
// Byte addresses
`define ADDR_OUT1_SEL 18'h08840
`define ADDR_MON_MODE 18'h08880
`define ADDR_MON_CH1_SEL 18'h08884
`define ADDR_MON_CH2_SEL 18'h08888
`define ADDR_MON_CH1_OFS 18'h0888C
`define ADDR_MON_CH2_OFS 18'h08890
`define ADDR_MON_CH1_SCL 18'h08894
`define ADDR_MON_CH2_SCL 18'h08898
`define ADDR_FORCE_VAL 18'h088C0
`define ADDR_FORCE_MASK 18'h088C4
`define ADDR_OUT_STATUS 18'h088C8
// Output setting fields
`define SEL_FUNC_MSB 7
`define SEL_POL_BIT 15
`define SEL_WRITE_MASK 16'h80FF
`define FUNC_NONE 8'h00
`define FUNC_LAST 8'h0B
`define FORCE_LSB 16
// Monitor settings
`define MON_SEL_MASK 16'h001F
`define MON_VAR_LAST 5'h18
`define MON_MODE_ABS 16'h0001
// Output range in millivolts
`define MON_LIMIT_MV 32'h00000FA0
// Reset values
`define RST_SEL 16'h0000
`define RST_SCALE 32'h00000001
`endif

// ==== verification/output_map_sva.sv ====
// Port assertions for the output map
`timescale 1ns/10ps
`include "output_map_regs.vh"
module output_map_sva
#(
   parameter NUM_OUT = 4
)
(
   // Clock, reset and bus
   input wire clock,
   input wire sys_rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Flag and outputs
   input wire brake_flag,
   input wire [NUM_OUT-1:0] out_pin,
   input wire signed [15:0] mon_ch1_mv,
   input wire signed [15:0] mon_ch2_mv
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Shadow of the first pin setting
   reg wr_ph;
   reg [15:0] sh;
   always @(posedge clock or posedge sys_rst)
      if (sys_rst)
      begin
         wr_ph <= 1'b0;
         sh <= 16'h0000;
      end
      else if (hready)
      begin
         wr_ph <= hsel && htrans[1] && hwrite && haddr == `ADDR_OUT1_SEL;
         if (wr_ph)
            sh <= hwdata[15:0] & `SEL_WRITE_MASK;
      end
   sequence s_rd_low;
      hsel && hready && htrans[1] && !hwrite && haddr[31:12] == 20'h00000;
   endsequence
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_unmapped_zero: assert property (s_rd_low |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_ch1_range: assert property (mon_ch1_mv <= 4000 && mon_ch1_mv >= -4000)
      else $error("channel one out of range");
   a_ch2_range: assert property (mon_ch2_mv <= 4000 && mon_ch2_mv >= -4000)
      else $error("channel two out of range");
   a_contact_follow: assert property (sh[7:0] == 8'h01 |=> out_pin[0] == $past(brake_flag ^ sh[15]))
      else $error("pin one does not follow brake");
   a_reserved_off: assert property (sh[7:0] > `FUNC_LAST |=> out_pin[0] == $past(sh[15]))
      else $error("reserved code pin not inactive");
   a_reset_clear: assert property (disable iff (1'b0) sys_rst |-> out_pin == 0 && mon_ch1_mv == 0)
      else $error("outputs not cleared in reset");
endmodule // output_map_sva
bind output_map output_map_sva #(.NUM_OUT(NUM_OUT)) u_output_map_sva (.clock(clock),
   .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .brake_flag(brake_flag), .out_pin(out_pin), .mon_ch1_mv(mon_ch1_mv), .mon_ch2_mv(mon_ch2_mv));

// ==== verification/status_wiring_model.sv ====
// Model of the drive signals wired into the output map
`timescale 1ns/10ps
module status_wiring_model
(
   // Clock and bench commands
   input wire clock,
   input wire [10:0] flag_cmd,
   input wire [31:0] var_base,
   // Signals into the block
   output reg [10:0] flags = 11'h000,
   output reg [799:0] vars = 800'h0
);
   integer k;
   // Word k carries the base plus k
   always @(posedge clock)
   begin
      flags <= flag_cmd;
      for (k = 0; k < 25; k = k + 1)
         vars[k*32 +: 32] <= var_base + k;
   end
endmodule // status_wiring_model

// ==== verification/tb_output_map.sv ====
// Self-checking bench for the output map
`timescale 1ns/10ps
`include "output_map_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_output_map;
   reg clock = 1'b0;
   reg sys_rst = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg [10:0] flag_cmd = 11'h000;
   reg [31:0] var_base = 32'h0;
   reg [31:0] rd;
   wire [31:0] hrdata;
   wire hreadyout, hresp;
   wire [10:0] flags;
   wire [799:0] vars;
   wire [3:0] out_pin;
   wire signed [15:0] mon_ch1_mv, mon_ch2_mv;
   integer mismatches = 0, cmp_count = 0, c, p;
   initial forever #20 clock = ~clock;
   status_wiring_model u_status_wiring_model (.clock(clock), .flag_cmd(flag_cmd),
      .var_base(var_base), .flags(flags), .vars(vars));
   output_map u_output_map (.clock(clock), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .brake_flag(flags[0]),
      .alarm_flag(flags[1]), .servo_ready_flag(flags[2]), .zero_speed_flag(flags[3]),
      .in_position_first(flags[4]), .torque_limit_flag(flags[5]),
      .speed_limit_flag(flags[6]), .speed_reached_flag(flags[7]), .warning_flag(flags[8]),
      .rotation_detected_flag(flags[9]), .in_position_second(flags[10]),
      .monitor_vars(vars), .out_pin(out_pin), .mon_ch1_mv(mon_ch1_mv), .mon_ch2_mv(mon_ch2_mv));
   task xfer(input [31:0] a, input w, input [31:0] d);
   begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clock);
      while (!hreadyout) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (!hreadyout) @(posedge clock);
      rd = hrdata;
   end
   endtask
   function integer exp_mv(input integer v, o, s, input m);
      integer r;
   begin
      r = (v - o) * 1000 / s;
      if (m && r < 0)
         r = -r;
      exp_mv = r > 4000 ? 4000 : (r < -4000 ? -4000 : r);
   end
   endfunction
   task mon_case(input [4:0] s1, input [31:0] o1, c1, input [4:0] s2, input [31:0] o2, c2,
      input m);
   begin
      xfer(`ADDR_MON_CH1_SEL, 1, s1);
      xfer(`ADDR_MON_CH2_SEL, 1, s2);
      xfer(`ADDR_MON_CH1_OFS, 1, o1);
      xfer(`ADDR_MON_CH2_OFS, 1, o2);
      xfer(`ADDR_MON_CH1_SCL, 1, c1);
      xfer(`ADDR_MON_CH2_SCL, 1, c2);
      xfer(`ADDR_MON_MODE, 1, m);
      repeat (4) @(posedge clock);
      `CHK(mon_ch1_mv, 16'(exp_mv(var_base + s1, o1, c1, m)))
      `CHK(mon_ch2_mv, 16'(exp_mv(var_base + s2, o2, c2, m)))
   end
   endtask
   task final_report;
   begin
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      #100000;
      mismatches++;
      final_report;
   end
   initial
   begin
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      xfer(`ADDR_OUT1_SEL, 0, 0);
      `CHK(rd, 32'h00000000)
      xfer(`ADDR_MON_CH1_SCL, 0, 0);
      `CHK(rd, 32'h00000001)
      xfer(32'h00000100, 0, 0);
      `CHK(rd, 32'h00000000)
      for (c = 0; c < 22; c++)
      begin
         p = (c / 2) % 4;
         xfer(`ADDR_OUT1_SEL + 4 * p, 1, {c[0], 7'h7F, 8'(c / 2 + 1)});
         xfer(`ADDR_OUT1_SEL + 4 * p, 0, 0);
         `CHK(rd, {16'h0000, c[0], 7'h00, 8'(c / 2 + 1)})
         flag_cmd <= 11'h001 << (c / 2);
         repeat (4) @(posedge clock);
         `CHK(out_pin[p], ~c[0])
         flag_cmd <= ~(11'h001 << (c / 2));
         repeat (4) @(posedge clock);
         `CHK(out_pin[p], c[0])
      end
      flag_cmd <= 11'h7FF;
      xfer(`ADDR_OUT1_SEL, 1, 32'h0000000C);
      repeat (4) @(posedge clock);
      `CHK(out_pin[0], 1'b0)
      xfer(`ADDR_OUT1_SEL, 1, 0);
      xfer(`ADDR_FORCE_MASK, 1, 32'h00010000);
      xfer(`ADDR_FORCE_VAL, 1, 32'h00010000);
      repeat (3) @(posedge clock);
      `CHK(out_pin[0], 1'b1)
      xfer(`ADDR_OUT_STATUS, 0, 0);
      `CHK(rd, 32'h00000001)
      xfer(`ADDR_FORCE_MASK, 1, 0);
      repeat (3) @(posedge clock);
      `CHK(out_pin[0], 1'b0)
      var_base <= 32'd1000;
      mon_case(5'h00, 998, 1, 5'h18, 1000, 10, 1'b0);
      mon_case(5'h00, 1010, 1, 5'h18, 1030, 10, 1'b1);
      mon_case(5'h00, 1010, 1, 5'h05, -2000, 1000, 1'b0);
      xfer(`ADDR_MON_CH2_OFS, 0, 0);
      `CHK(rd, 32'hFFFFF830)
      final_report;
   end
endmodule // tb_output_map
